// *** gpso_pkg.sv ***
// Shared constants, types and decode function for the pin sync and override port.
package gpso_pkg;

   // ------------------------------------------------------------
   // Geometry and reset values
   // ------------------------------------------------------------
   localparam int         PORT_W    = 8;
   localparam int         ADDR_W    = 12;
   localparam int         DATA_W    = 32;
   localparam logic       RST_BIT   = 1'b0;
   localparam logic [1:0] WARM_DONE = 2'h3;

   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_OUT = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_DIR = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_PUE = 12'h008;
   localparam logic [ADDR_W-1:0] OFS_PIN = 12'h00C;

   typedef enum logic [4:0] {
      SEL_OUT  = 5'b00001,
      SEL_DIR  = 5'b00010,
      SEL_PUE  = 5'b00100,
      SEL_PIN  = 5'b01000,
      SEL_NONE = 5'b10000
   } gpso_sel_t;

   // Address decode is shared by the read path and the error answer.
   function automatic gpso_sel_t gpso_decode(input logic [ADDR_W-1:0] a);
      gpso_sel_t s;
      if (a == OFS_OUT) begin
         s = SEL_OUT;
      end else if (a == OFS_DIR) begin
         s = SEL_DIR;
      end else if (a == OFS_PUE) begin
         s = SEL_PUE;
      end else if (a == OFS_PIN) begin
         s = SEL_PIN;
      end else begin
         s = SEL_NONE;
      end
      return s;
   endfunction

endpackage

// *** gpso_if.sv ***
// Carrier between the register bank and the per-pin override cell.
`timescale 1ns/100ps
interface gpso_if #(parameter int N = gpso_pkg::PORT_W);
   logic [N-1:0] dir;
   logic [N-1:0] out_val;
   logic [N-1:0] pue;
   logic [N-1:0] clamped_in;

   modport regs (output dir, output out_val, output pue, input clamped_in);
   modport pins (input dir, input out_val, input pue, output clamped_in);
endinterface

// *** gpso_sync.sv ***
// Two-stage synchronizer feeding the pin input bits.
`timescale 1ns/100ps
module gpso_sync #(
   parameter int N = gpso_pkg::PORT_W
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [N-1:0] d,
   output logic      [N-1:0] q
);

   typedef struct packed {
      logic [N-1:0] stage1;
      logic [N-1:0] stage2;
   } gpso_sync_t;

   gpso_sync_t st;
   gpso_sync_t next_st;

   // ------------------------------------------------------------
   // Capture stage then pin input stage
   // ------------------------------------------------------------
   // written value takes same stages
   always_comb begin
      next_st        = st;
      next_st.stage1 = d;
      next_st.stage2 = st.stage1;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign q = st.stage2;

endmodule

// *** gpso_pin.sv ***
// Per-pin override, sleep clamp and pad drive logic.
`timescale 1ns/100ps
module gpso_pin #(
   parameter int           N      = gpso_pkg::PORT_W,
   parameter logic [N-1:0] PU_OVR = '1,
   parameter logic [N-1:0] DD_OVR = '1,
   parameter logic [N-1:0] PV_OVR = '1,
   parameter logic [N-1:0] PT_OVR = '1,
   parameter logic [N-1:0] IE_OVR = '1
) (
   input  wire logic         clk,
   input  wire logic         rst,
   gpso_if.pins              sigs,
   input  wire logic [N-1:0] pad_in,
   input  wire logic         sleep,
   input  wire logic [N-1:0] ext_int_en,
   input  wire logic [N-1:0] pullup_override_en,
   input  wire logic [N-1:0] pullup_override_val,
   input  wire logic [N-1:0] direction_override_en,
   input  wire logic [N-1:0] direction_override_val,
   input  wire logic [N-1:0] value_override_en,
   input  wire logic [N-1:0] value_override_val,
   input  wire logic [N-1:0] toggle_override_en,
   input  wire logic [N-1:0] input_enable_override_en,
   input  wire logic [N-1:0] input_enable_override_val,
   output logic      [N-1:0] pad_out,
   output logic      [N-1:0] pad_oe,
   output logic      [N-1:0] pullup_on,
   output logic      [N-1:0] raw_digital_input,
   output logic      [N-1:0] analog_pad_tap
);

   typedef struct packed {
      logic [N-1:0] oe;
      logic [N-1:0] drv;
      logic [N-1:0] pu;
      logic [N-1:0] di;
      logic [N-1:0] ana;
   } gpso_pin_t;

   gpso_pin_t    st;
   gpso_pin_t    next_st;
   logic [N-1:0] ie;
   logic [N-1:0] pu_en;
   logic [N-1:0] dd_en;
   logic [N-1:0] pv_en;
   logic [N-1:0] pt_en;
   logic [N-1:0] ie_en;

   // ------------------------------------------------------------
   // Override gating
   // ------------------------------------------------------------
   always_comb begin
      pu_en = pullup_override_en & PU_OVR;
      dd_en = direction_override_en & DD_OVR;
      pv_en = value_override_en & PV_OVR;
      pt_en = toggle_override_en & PT_OVR;
      ie_en = input_enable_override_en & IE_OVR;
      ie = (ie_en & input_enable_override_val) | (~ie_en & ~({N{sleep}} & ~ext_int_en));
      sigs.clamped_in = pad_in & ie;
      next_st = st;
      next_st.oe = (dd_en & direction_override_val) | (~dd_en & sigs.dir);
      // value and toggle select
      // Gating with the enable before the flop keeps the pad output a bare register.
      next_st.drv = ((pv_en & value_override_val) | (~pv_en & (sigs.out_val ^ pt_en))) & next_st.oe;
      next_st.pu  = (pu_en & pullup_override_val) | (~pu_en & sigs.pue);
      next_st.di  = sigs.clamped_in;
      next_st.ana = pad_in;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign pad_oe            = st.oe;
   assign pad_out           = st.drv;
   assign pullup_on         = st.pu;
   assign raw_digital_input = st.di;
   assign analog_pad_tap    = st.ana;

endmodule

// *** gpso_top.sv ***
// Port block: APB register bank, pin synchronizer and per-pin overrides.
// How it works
// - pin input bit readable regardless of direction
// - input passes two synchronizing stages
// - external change reaches input bit bounded
// - written value reaches input bit later
// - sleep clamps digital input to zero
// - enabled external interrupt pins skip clamp
// - clamp release shows as pin change
// - pull-ups off while reset active
// - pull-up override else register bit
// - direction override else direction bit
// - value override else output bit
// - toggle override inverts output bit
// - input enable override else sleep state
// - raw input given before synchronizer
// - analog tap straight from pad
// - strobes shared, overrides per pin
// - direction one drives, zero inputs
// - writing one to input toggles output
// - reset tristates all pins
`timescale 1ns/100ps
module gpso_top #(
   parameter int           N      = gpso_pkg::PORT_W,
   parameter logic [N-1:0] PU_OVR = '1,
   parameter logic [N-1:0] DD_OVR = '1,
   parameter logic [N-1:0] PV_OVR = '1,
   parameter logic [N-1:0] PT_OVR = '1,
   parameter logic [N-1:0] IE_OVR = '1
) (
   input  wire logic                        clk,
   input  wire logic                        rst,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [gpso_pkg::ADDR_W-1:0] paddr,
   input  wire logic [gpso_pkg::DATA_W-1:0] pwdata,
   output logic      [gpso_pkg::DATA_W-1:0] prdata,
   output logic                             pready,
   output logic                             pslverr,
   input  wire logic [N-1:0]                pad_in,
   output logic      [N-1:0]                pad_out,
   output logic      [N-1:0]                pad_oe,
   output logic      [N-1:0]                pullup_on,
   input  wire logic                        sleep,
   input  wire logic [N-1:0]                ext_int_en,
   input  wire logic [N-1:0]                pullup_override_en,
   input  wire logic [N-1:0]                pullup_override_val,
   input  wire logic [N-1:0]                direction_override_en,
   input  wire logic [N-1:0]                direction_override_val,
   input  wire logic [N-1:0]                value_override_en,
   input  wire logic [N-1:0]                value_override_val,
   input  wire logic [N-1:0]                toggle_override_en,
   input  wire logic [N-1:0]                input_enable_override_en,
   input  wire logic [N-1:0]                input_enable_override_val,
   output logic      [N-1:0]                raw_digital_input,
   output logic      [N-1:0]                analog_pad_tap,
   output logic      [N-1:0]                pin_change
);

   typedef struct packed {
      logic [N-1:0]                  out_val;
      logic [N-1:0]                  dir;
      logic [N-1:0]                  pue;
      logic [N-1:0]                  pin_prev;
      logic [N-1:0]                  change;
      logic [gpso_pkg::DATA_W-1:0]   rdata;
      logic                          ready;
      logic                          err;
      logic [1:0]                    warm;
   } gpso_top_t;

   gpso_top_t          st;
   gpso_top_t          next_st;
   logic [N-1:0]       pin_input_bit;
   gpso_pkg::gpso_sel_t sel;
   logic               setup;
   logic               wr_go;
   logic [N-1:0]       wbits;

   gpso_if #(.N(N)) sigs ();

   // ------------------------------------------------------------
   // Submodules
   // ------------------------------------------------------------
   // common strobes, per-pin override vectors
   gpso_pin #(
      .N      (N),
      .PU_OVR (PU_OVR),
      .DD_OVR (DD_OVR),
      .PV_OVR (PV_OVR),
      .PT_OVR (PT_OVR),
      .IE_OVR (IE_OVR)
   ) u_pin (
      .clk                       (clk),
      .rst                       (rst),
      .sigs                      (sigs.pins),
      .pad_in                    (pad_in),
      .sleep                     (sleep),
      .ext_int_en                (ext_int_en),
      .pullup_override_en        (pullup_override_en),
      .pullup_override_val       (pullup_override_val),
      .direction_override_en     (direction_override_en),
      .direction_override_val    (direction_override_val),
      .value_override_en         (value_override_en),
      .value_override_val        (value_override_val),
      .toggle_override_en        (toggle_override_en),
      .input_enable_override_en  (input_enable_override_en),
      .input_enable_override_val (input_enable_override_val),
      .pad_out                   (pad_out),
      .pad_oe                    (pad_oe),
      .pullup_on                 (pullup_on),
      .raw_digital_input         (raw_digital_input),
      .analog_pad_tap            (analog_pad_tap)
   );

   gpso_sync #(.N(N)) u_sync (
      .clk (clk),
      .rst (rst),
      .d   (sigs.clamped_in),
      .q   (pin_input_bit)
   );

   assign sigs.dir     = st.dir;
   assign sigs.out_val = st.out_val;
   assign sigs.pue     = st.pue;

   // ------------------------------------------------------------
   // APB slave and register bank
   // ------------------------------------------------------------
   always_comb begin
      sel     = gpso_pkg::gpso_decode(paddr);
      setup   = psel & ~penable;
      wr_go   = psel & penable & st.ready & pwrite & ~st.err;
      wbits   = pwdata[N-1:0];
      next_st = st;
      // Ready is raised for the access phase only, so every transfer has zero wait states.
      next_st.ready = setup;
      next_st.err   = setup & (sel == gpso_pkg::SEL_NONE);
      if (setup & ~pwrite) begin
         next_st.rdata = '0;
         if (sel == gpso_pkg::SEL_OUT) begin
            next_st.rdata[N-1:0] = st.out_val;
         end else if (sel == gpso_pkg::SEL_DIR) begin
            next_st.rdata[N-1:0] = st.dir;
         end else if (sel == gpso_pkg::SEL_PUE) begin
            next_st.rdata[N-1:0] = st.pue;
         end else if (sel == gpso_pkg::SEL_PIN) begin
            next_st.rdata[N-1:0] = pin_input_bit;
         end
      end
      if (wr_go) begin
         if (sel == gpso_pkg::SEL_OUT) begin
            next_st.out_val = wbits;
         end else if (sel == gpso_pkg::SEL_DIR) begin
            next_st.dir = wbits;
         end else if (sel == gpso_pkg::SEL_PUE) begin
            next_st.pue = wbits;
         end else if (sel == gpso_pkg::SEL_PIN) begin
            next_st.out_val = st.out_val ^ wbits;
         end
      end
      // change seen on input bit, clamp release included
      next_st.pin_prev = pin_input_bit;
      next_st.change   = pin_input_bit ^ st.pin_prev;
      if (st.warm != gpso_pkg::WARM_DONE) begin
         next_st.warm   = st.warm + 2'h1;
         next_st.change = '0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st          <= '0;
         st.out_val  <= {N{gpso_pkg::RST_BIT}};
         st.dir      <= {N{gpso_pkg::RST_BIT}};
         st.pue      <= {N{gpso_pkg::RST_BIT}};
      end else begin
         st <= next_st;
      end
   end

   assign prdata     = st.rdata;
   assign pready     = st.ready;
   assign pslverr    = st.err;
   assign pin_change = st.change;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_sync_delay: assert property (st.warm == gpso_pkg::WARM_DONE |-> pin_input_bit == $past(sigs.clamped_in, 2))
      else $error("Pin input bit does not follow clamped input by two cycles.");

   a_sleep_clamp: assert property (sleep && !ext_int_en[0] && !input_enable_override_en[0] |=> raw_digital_input[0] == 1'b0)
      else $error("Sleep clamp failed on pin zero.");

   a_int_noclamp: assert property (sleep && ext_int_en[0] && !input_enable_override_en[0] |=> raw_digital_input[0] == $past(pad_in[0]))
      else $error("Interrupt pin was clamped in sleep.");

   a_dir_drive: assert property (!direction_override_en[0] |=> pad_oe[0] == $past(st.dir[0]))
      else $error("Output enable does not follow direction bit.");

   a_value_ovr: assert property (value_override_en[0] && PV_OVR[0] |=> pad_out[0] == ($past(value_override_val[0]) & pad_oe[0]))
      else $error("Value override not driven to pad.");

   a_pullup_sel: assert property (!pullup_override_en[0] |=> pullup_on[0] == $past(st.pue[0]))
      else $error("Pull-up does not follow enable bit.");

   a_pin_toggle: assert property (wr_go && sel == gpso_pkg::SEL_PIN |=> st.out_val == ($past(st.out_val) ^ $past(wbits)))
      else $error("Write to input register did not toggle output bits.");

   a_reset_safe: assert property (@(posedge clk) disable iff (1'b0) $past(rst) |-> pad_oe == '0 && pullup_on == '0)
      else $error("Pad driver or pull-up active after reset.");

   a_apb_answer: assert property (setup |=> pready ##1 !pready)
      else $error("Access phase was not answered in one cycle.");

   a_pin_read: assert property (setup && !pwrite && sel == gpso_pkg::SEL_PIN |=> prdata[N-1:0] == $past(pin_input_bit))
      else $error("Read of the input register did not return the synchronized pins.");

   // Unmapped reads answer zero with an error.
   a_bad_read: assert property (setup && !pwrite && sel == gpso_pkg::SEL_NONE |=> pslverr && prdata == '0)
      else $error("Unmapped read was not refused.");

   a_dir_write: assert property (wr_go && sel == gpso_pkg::SEL_DIR |=> st.dir == $past(wbits))
      else $error("Direction write did not land.");

   a_change_pulse: assert property (st.warm == gpso_pkg::WARM_DONE |=> pin_change == ($past(pin_input_bit) ^ $past(pin_input_bit, 2)))
      else $error("Pin change pulse does not match the input bit history.");

   a_dir_ovr: assert property (direction_override_en[0] && DD_OVR[0] |=> pad_oe[0] == $past(direction_override_val[0]))
      else $error("Direction override not applied to output enable.");

   a_pullup_ovr: assert property (pullup_override_en[0] && PU_OVR[0] |=> pullup_on[0] == $past(pullup_override_val[0]))
      else $error("Pull-up override not applied.");

   a_toggle_ovr: assert property (toggle_override_en[0] && PT_OVR[0] && !(value_override_en[0] && PV_OVR[0])
                                  |=> pad_out[0] == (~$past(st.out_val[0]) & pad_oe[0]))
      else $error("Toggle override did not invert the driven value.");

   a_ie_override: assert property ((input_enable_override_en & IE_OVR) != '0
                                   |=> ((raw_digital_input ^ ($past(pad_in) & $past(input_enable_override_val)))
                                        & $past(input_enable_override_en & IE_OVR)) == '0)
      else $error("Input enable override not applied to the raw input.");

   a_analog_tap: assert property (1'b1 |=> analog_pad_tap == $past(pad_in))
      else $error("Analog tap does not follow the pad.");

   c_toggle_write: cover property (wr_go && sel == gpso_pkg::SEL_PIN);
   c_sleep_wake:   cover property (sleep ##1 !sleep ##[1:4] pin_change != '0);
   c_bad_address:  cover property (pready && pslverr);
   c_pin_read:     cover property (setup && !pwrite && sel == gpso_pkg::SEL_PIN);
   c_value_drive:  cover property (value_override_en[0] && pad_oe[0]);

endmodule

// *** gpso_pad_model.sv ***
// Behavioural model of the pads and the peripheral that listens to the raw input.
`timescale 1ns/100ps
module gpso_pad_model #(
   parameter int N = gpso_pkg::PORT_W
) (
   input  wire logic         clk,
   input  wire logic [N-1:0] pad_out,
   input  wire logic [N-1:0] pad_oe,
   input  wire logic [N-1:0] pullup_on,
   input  wire logic [N-1:0] ext_en,
   input  wire logic [N-1:0] ext_val,
   input  wire logic [N-1:0] raw_digital_input,
   output logic      [N-1:0] pad_in,
   output logic      [N-1:0] raw_synced
);
   // ------------------------------------------------------------
   // Pad level
   // ------------------------------------------------------------
   logic [N-1:0] float_pat = '0;
   logic [N-1:0] sync_a    = '0;

   // An undriven pad without pull-up wobbles every cycle, so a floating
   // input can never pass for a steady level.
   always_ff @(posedge clk) begin
      float_pat <= ~float_pat;
   end

   assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) | (~pad_oe & ~ext_en & pullup_on)
                 | (~pad_oe & ~ext_en & ~pullup_on & float_pat);

   always_ff @(posedge clk) begin
      sync_a     <= raw_digital_input;
      raw_synced <= sync_a;
   end
endmodule

// *** gpio_pin_sync_override_bench.sv ***
// Self-checking testbench for the pin sync and override port.
`timescale 1ns/100ps
module gpio_pin_sync_override_bench;
   // ------------------------------------------------------------
   // Signals, model and design
   // ------------------------------------------------------------
   localparam int N = gpso_pkg::PORT_W;
   logic              clk = 1'b0;
   logic              rst = 1'b1;
   logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sleep = 1'b0;
   logic [11:0]       paddr = '0;
   logic [31:0]       pwdata = '0, prdata, rd;
   logic              pready, pslverr, err;
   logic [N-1:0]      pad_in, pad_out, pad_oe, pullup_on, raw_di, ana, chg, synced;
   logic [N-1:0]      ext_en = '1, ext_val = '0, eii = '0, pu_e = '0, pu_v = '0, dd_e = '0, dd_v = '0;
   logic [N-1:0]      pv_e = '0, pv_v = '0, pt_e = '0, ie_e = '0, ie_v = '0;
   int                n_fail = 0, num_checks = 0, cyc = 0;

   gpso_pad_model #(.N(N)) pads (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe), .pullup_on(pullup_on),
      .ext_en(ext_en), .ext_val(ext_val), .raw_digital_input(raw_di), .pad_in(pad_in), .raw_synced(synced));

   gpso_top #(.N(N)) DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pullup_on(pullup_on), .sleep(sleep),
      .ext_int_en(eii), .pullup_override_en(pu_e), .pullup_override_val(pu_v),
      .direction_override_en(dd_e), .direction_override_val(dd_v), .value_override_en(pv_e),
      .value_override_val(pv_v), .toggle_override_en(pt_e), .input_enable_override_en(ie_e),
      .input_enable_override_val(ie_v), .raw_digital_input(raw_di), .analog_pad_tap(ana),
      .pin_change(chg));

   initial begin
      forever #10 clk = ~clk;
   end

   // The ceiling of 3000 cycles is over twenty times the hundred-odd cycles that the tests need.
   initial begin
      forever begin
         @(posedge clk);
         cyc++;
         if (cyc == 3000) begin
            n_fail++;
            finish_test();
         end
      end
   end

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Zero-wait slave, but the master still waits on pready under a bound.
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) n_fail++;
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rd, exp);
   endtask

   task finish_test;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      int k;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      #1;
      check(32'(pad_oe), 32'h0);
      check(32'(pullup_on), 32'h0);
      rdchk(gpso_pkg::OFS_OUT, 32'h0);
      rdchk(gpso_pkg::OFS_DIR, 32'h0);
      rdchk(gpso_pkg::OFS_PUE, 32'h0);
      apb(1'b1, 12'h010, 32'hFF);
      check(32'(err), 32'h1);
      rdchk(12'h010, 32'h0);
      $display("test reset and map done");
      apb(1'b1, gpso_pkg::OFS_OUT, 32'hA5);
      apb(1'b1, gpso_pkg::OFS_DIR, 32'hFF);
      settle(3);
      check(32'(pad_oe), 32'hFF);
      check(32'(pad_out), 32'hA5);
      apb(1'b1, gpso_pkg::OFS_OUT, 32'h5A);
      settle(2);
      rdchk(gpso_pkg::OFS_PIN, 32'h5A);
      apb(1'b1, gpso_pkg::OFS_PIN, 32'h0F);
      rdchk(gpso_pkg::OFS_OUT, 32'h55);
      apb(1'b1, gpso_pkg::OFS_DIR, 32'h00);
      apb(1'b1, gpso_pkg::OFS_PIN, 32'hF0);
      rdchk(gpso_pkg::OFS_OUT, 32'hA5);
      $display("test output and toggle done");
      apb(1'b1, gpso_pkg::OFS_PUE, 32'hF0);
      ext_en  <= 8'h0F;
      ext_val <= 8'h0C;
      settle(3);
      check(32'(pullup_on), 32'hF0);
      check(32'(pad_oe), 32'h00);
      rdchk(gpso_pkg::OFS_PIN, 32'hFC);
      check(32'(raw_di), 32'hFC);
      check(32'(synced), 32'hFC);
      check(32'(ana), 32'hFC);
      $display("test input done");
      ext_en  <= 8'hFF;
      ext_val <= 8'hFF;
      eii     <= 8'h0F;
      sleep   <= 1'b1;
      settle(3);
      rdchk(gpso_pkg::OFS_PIN, 32'h0F);
      check(32'(ana), 32'hFF);
      ie_e <= 8'hF0;
      ie_v <= 8'h30;
      settle(3);
      rdchk(gpso_pkg::OFS_PIN, 32'h3F);
      ie_e <= 8'h00;
      eii  <= 8'h00;
      settle(4);
      rdchk(gpso_pkg::OFS_PIN, 32'h00);
      sleep <= 1'b0;
      k = 0;
      do begin
         settle(1);
         k++;
      end while (chg === 8'h00 && k < 8);
      check(32'(chg), 32'hFF);
      $display("test sleep clamp done");
      @(posedge clk);
      pu_e <= 8'hFF;
      pu_v <= 8'h55;
      dd_e <= 8'hFF;
      dd_v <= 8'h0F;
      pv_e <= 8'hFF;
      pv_v <= 8'h33;
      settle(3);
      check(32'(pullup_on), 32'h55);
      check(32'(pad_oe), 32'h0F);
      check(32'(pad_out), 32'h03);
      @(posedge clk);
      pv_e <= 8'h00;
      pt_e <= 8'hFF;
      settle(3);
      check(32'(pad_out), 32'h0A);
      $display("test overrides done");
      @(posedge clk);
      pu_v <= 8'hFF;
      dd_v <= 8'hFF;
      rst  <= 1'b1;
      settle(2);
      check(32'(pullup_on), 32'h00);
      check(32'(pad_oe), 32'h00);
      @(posedge clk);
      rst <= 1'b0;
      $display("test second reset done");
      finish_test();
   end
endmodule
